// ---- rtl/fault_retry_power_fail_ctrl.sv ----
// Power-failure stop sequencer and automatic fault retry controller
//
// Behaviour
// - Stop select 0 coasts, 1 decelerates to stop, 2 decelerates then re-accelerates.
// - On supply loss with decel stop, bus-regulated decel down to 0 Hz.
// - Select 1: power back during decel still stops; restart needs start off then on.
// - Coast time other than 9999 disables power-fail stop in favour of restart.
// - Select 1: no start at power-up with start held; release and reassert first.
// - Select 2: power back during decel re-accelerates to set frequency.
// - Select 2: start released during loss gives normal-time deceleration.
// - Power-fail flag high during loss deceleration and the stop after it.
// - Terminal code 46 routes power-fail flag positive, 146 negative.
// - No power-fail stop behaviour while stopped or tripped.
// - Retryable trip clears after wait time and restarts from starting frequency.
// - Count 0 no retry; 1..10 silent retries; above 100 count-100 with alarm.
// - Consecutive failures beyond count raise retry-excess fault and trip.
// - Wait time 0.1 to 360 s, default 1 s, from trip to retry.
// - Success after fault-free run over four wait times; clears failure count.
// - Success counter reads cumulative successes; writing zero clears it.
// - Retry flag high during retry; terminal code 64 positive, 164 negative.
// - Fault select 0..5 chooses retried fault classes per class table.
// - Only the first fault of a retry episode is kept as stored error.
// - Retry reset keeps thermal and brake duty data, unlike power-on reset.
// - Parameter-storage fault found at power-up is never retried.
// - Non-retry fault during wait abandons retry and stays displayed.
// - Coast time other than 9999 makes retry use flying restart timing.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fault_retry_power_fail_ctrl #(
  parameter int TICK_CYCLES = retry_pf_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Controller start inputs
  input wire logic forward_start_input_in,
  input wire logic reverse_start_input_in,
  // Drive status
  input wire logic undervolt_in,
  input wire logic freq_zero_in,
  input wire logic fault_in,
  input wire logic [4:0] fault_code_in,
  input wire logic manual_reset_in,
  // Drive commands
  output logic run_enable_out,
  output logic bus_reg_decel_out,
  output logic normal_decel_out,
  output logic output_shutoff_out,
  output logic reaccel_out,
  output logic fault_reset_out,
  output logic flying_restart_out,
  output logic thermal_clear_out,
  // Fault and flag outputs
  output logic fault_alarm_out,
  output logic retry_excess_fault_out,
  output logic [4:0] shown_fault_out,
  output logic power_fail_decel_flag_out,
  output logic retry_active_flag_out,
  output logic [2:0] terminal_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Fault classes retried under each select setting
  function automatic logic retryable(input logic [2:0] sel, input logic [4:0] code);
    logic oc;
    logic ov;
    logic th;
    oc = code inside {5'h01, 5'h02, 5'h03};
    ov = code inside {5'h04, 5'h05, 5'h06};
    th = code inside {5'h07, 5'h08, 5'h0C};
    case (sel)
      3'h0: retryable = (code != 5'h00) && (code != 5'h16);
      3'h1: retryable = oc;
      3'h2: retryable = ov;
      3'h3: retryable = oc | ov;
      3'h4: retryable = (code != 5'h00) && (code != 5'h16) && !th;
      3'h5: retryable = (code == 5'h01) || (code == 5'h03);
      default: retryable = 1'b0;
    endcase
  endfunction

  // Allowed retries from the count setting; 11..100 gives none
  function automatic logic [7:0] retry_limit(input logic [7:0] set);
    if (set <= retry_pf_pkg::RETRY_CNT_MAX_PLAIN) begin
      retry_limit = set;
    end else if (set > retry_pf_pkg::RETRY_CNT_ALARM_BASE) begin
      retry_limit = set - retry_pf_pkg::RETRY_CNT_ALARM_BASE;
    end else begin
      retry_limit = 8'h00;
    end
  endfunction

  // Terminal function code applied to the two flags
  function automatic logic term_map(input logic [7:0] code, input logic pf, input logic rt);
    case (code)
      retry_pf_pkg::TERM_PF_POS: term_map = pf;
      retry_pf_pkg::TERM_PF_NEG: term_map = !pf;
      retry_pf_pkg::TERM_RT_POS: term_map = rt;
      retry_pf_pkg::TERM_RT_NEG: term_map = !rt;
      default: term_map = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  retry_pf_pkg::state_t s_q;
  retry_pf_pkg::state_t s_d;
  logic start;
  logic pf_allowed;
  logic tripped;
  logic [15:0] wait_ticks;
  logic [15:0] ok_ticks;

  assign start = forward_start_input_in | reverse_start_input_in;
  // Trip is held from the fault until the retry fires or a manual reset
  assign tripped = (s_q.rt == retry_pf_pkg::RT_WAIT) || (s_q.rt == retry_pf_pkg::RT_LOCK);
  // power-fail stop only with restart disabled
  assign pf_allowed = (s_q.cfg.coast == retry_pf_pkg::COAST_OFF) && s_q.run_en && !tripped;
  assign wait_ticks = {4'h0, s_q.cfg.wait_t};
  assign ok_ticks = 16'(s_q.cfg.wait_t * retry_pf_pkg::SUCCESS_MULT);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic fire;
    logic can_retry;
    logic [11:0] wt;
    fire = 1'b0;
    can_retry = 1'b0;
    wt = wdata_in[11:0];
    s_d = s_q;
    s_d.reaccel = 1'b0;
    s_d.fault_reset = 1'b0;
    s_d.thermal_clear = 1'b0;
    s_d.rdata = 32'h0000_0000;

    // 0.1 s time base
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
    end

    // Register writes
    if (wr_in) begin
      case (addr_in)
        retry_pf_pkg::OFS_STOP_SEL: s_d.cfg.stop_sel = (wdata_in[1:0] == 2'h3) ? s_q.cfg.stop_sel : wdata_in[1:0];
        retry_pf_pkg::OFS_COAST: s_d.cfg.coast = wdata_in[13:0];
        retry_pf_pkg::OFS_RETRY_SEL: s_d.cfg.retry_sel = (wdata_in[2:0] > 3'h5) ? s_q.cfg.retry_sel : wdata_in[2:0];
        retry_pf_pkg::OFS_RETRY_CNT: s_d.cfg.retry_cnt = wdata_in[7:0];
        // wait time clamped to 0.1..360 s
        retry_pf_pkg::OFS_RETRY_WAIT: begin
          if (wt < retry_pf_pkg::RETRY_WAIT_MIN) begin
            s_d.cfg.wait_t = retry_pf_pkg::RETRY_WAIT_MIN;
          end else if (wt > retry_pf_pkg::RETRY_WAIT_MAX) begin
            s_d.cfg.wait_t = retry_pf_pkg::RETRY_WAIT_MAX;
          end else begin
            s_d.cfg.wait_t = wt;
          end
        end
        // writing zero clears the success count
        retry_pf_pkg::OFS_SUCCESS: begin
          if (wdata_in == 32'h0000_0000) begin
            s_d.success = 16'h0000;
          end
        end
        retry_pf_pkg::OFS_TERM: s_d.cfg.term = wdata_in[23:0];
        default: ;
      endcase
    end

    // Register reads, answered the next cycle
    if (rd_in) begin
      case (addr_in)
        retry_pf_pkg::OFS_STOP_SEL: s_d.rdata = {30'h0, s_q.cfg.stop_sel};
        retry_pf_pkg::OFS_COAST: s_d.rdata = {18'h0, s_q.cfg.coast};
        retry_pf_pkg::OFS_RETRY_SEL: s_d.rdata = {29'h0, s_q.cfg.retry_sel};
        retry_pf_pkg::OFS_RETRY_CNT: s_d.rdata = {24'h0, s_q.cfg.retry_cnt};
        retry_pf_pkg::OFS_RETRY_WAIT: s_d.rdata = {20'h0, s_q.cfg.wait_t};
        retry_pf_pkg::OFS_SUCCESS: s_d.rdata = {16'h0, s_q.success};
        retry_pf_pkg::OFS_TERM: s_d.rdata = {8'h0, s_q.cfg.term};
        retry_pf_pkg::OFS_STATUS: begin
          s_d.rdata = {5'h0, s_q.first_fault, s_q.fails, 4'h0, s_q.block,
                       s_q.excess, 4'h0, s_q.rt, s_q.pf};
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Start gating
    // a held start is released and reasserted before the first run
    // same after a select-1 power-fail stop
    if (!start) begin
      s_d.block = 1'b0;
    end
    s_d.run_en = start && !s_d.block && !tripped && (s_q.pf != retry_pf_pkg::PF_STOP);
    if (s_q.run_en) begin
      s_d.powerup = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-fail sequence
    // select 0 just shuts the output off while the supply is low
    s_d.shutoff = undervolt_in && (s_q.cfg.stop_sel == 2'h0) && s_q.run_en;
    case (s_q.pf)
      retry_pf_pkg::PF_IDLE: begin
        if (undervolt_in && pf_allowed && (s_q.cfg.stop_sel != 2'h0)) begin
          s_d.pf = retry_pf_pkg::PF_DECEL;
        end
      end
      retry_pf_pkg::PF_DECEL: begin
        if (tripped) begin
          s_d.pf = retry_pf_pkg::PF_IDLE;
        end else if (s_q.cfg.stop_sel == 2'h2 && !start) begin
          // released start falls back to normal decel time
          s_d.pf = retry_pf_pkg::PF_NORM;
        end else if (freq_zero_in) begin
          s_d.pf = retry_pf_pkg::PF_STOP;
        end else if (s_q.cfg.stop_sel == 2'h2 && !undervolt_in) begin
          // supply back, climb to the set frequency
          s_d.pf = retry_pf_pkg::PF_IDLE;
          s_d.reaccel = 1'b1;
        end
      end
      retry_pf_pkg::PF_NORM: begin
        if (freq_zero_in || tripped) begin
          s_d.pf = retry_pf_pkg::PF_IDLE;
        end
      end
      // select 1 stays stopped until start is cycled
      retry_pf_pkg::PF_STOP: begin
        if (s_q.cfg.stop_sel == 2'h1) begin
          s_d.block = 1'b1;
          if (!start) begin
            s_d.pf = retry_pf_pkg::PF_IDLE;
            s_d.block = 1'b0;
          end
        end else if (!undervolt_in || !start) begin
          s_d.pf = retry_pf_pkg::PF_IDLE;
        end
      end
      default: s_d.pf = retry_pf_pkg::PF_IDLE;
    endcase
    s_d.bus_decel = (s_d.pf == retry_pf_pkg::PF_DECEL);
    s_d.norm_decel = (s_d.pf == retry_pf_pkg::PF_NORM);

    ////////////////////////////////////////////////////////////////////////
    // Retry sequence
    // fault class filter
    // storage fault at power-up is excluded
    can_retry = retryable(s_q.cfg.retry_sel, fault_code_in) &&
                !(s_q.powerup && fault_code_in == retry_pf_pkg::F_PE);
    case (s_q.rt)
      retry_pf_pkg::RT_IDLE, retry_pf_pkg::RT_RUN: begin
        if (s_q.rt == retry_pf_pkg::RT_RUN && s_q.tick) begin
          s_d.timer = s_q.timer + 16'h0001;
          // success past four wait times clears the failure run
          if (s_q.timer >= ok_ticks) begin
            s_d.rt = retry_pf_pkg::RT_IDLE;
            s_d.success = s_q.success + 16'h0001;
            s_d.fails = 8'h00;
            s_d.first_fault = retry_pf_pkg::F_NONE;
          end
        end
        if (fault_in) begin
          s_d.timer = 16'h0000;
          // keep only the first fault of the episode
          if (s_q.first_fault == retry_pf_pkg::F_NONE || s_q.rt == retry_pf_pkg::RT_IDLE) begin
            s_d.first_fault = retry_pf_pkg::fault_t'(fault_code_in);
          end
          s_d.shown_fault = retry_pf_pkg::fault_t'(fault_code_in);
          if (!can_retry || retry_limit(s_q.cfg.retry_cnt) == 8'h00) begin
            s_d.rt = retry_pf_pkg::RT_LOCK;
          end else if (s_q.rt == retry_pf_pkg::RT_RUN && s_q.fails >= retry_limit(s_q.cfg.retry_cnt)) begin
            // failures beyond the limit trip on retry excess
            s_d.rt = retry_pf_pkg::RT_LOCK;
            s_d.excess = 1'b1;
            s_d.shown_fault = retry_pf_pkg::F_RET;
          end else begin
            s_d.rt = retry_pf_pkg::RT_WAIT;
            s_d.fails = (s_q.rt == retry_pf_pkg::RT_IDLE) ? 8'h01 : s_q.fails + 8'h01;
          end
        end
      end
      retry_pf_pkg::RT_WAIT: begin
        if (s_q.tick) begin
          s_d.timer = s_q.timer + 16'h0001;
        end
        if (fault_in && !can_retry) begin
          // unselected fault ends the retry, still shown
          s_d.rt = retry_pf_pkg::RT_LOCK;
          s_d.shown_fault = retry_pf_pkg::fault_t'(fault_code_in);
        end else if (s_q.tick && s_q.timer + 16'h0001 >= wait_ticks) begin
          fire = 1'b1;
        end
      end
      retry_pf_pkg::RT_LOCK: begin
        if (manual_reset_in) begin
          s_d.rt = retry_pf_pkg::RT_IDLE;
          s_d.fails = 8'h00;
          s_d.excess = 1'b0;
          s_d.shown_fault = retry_pf_pkg::F_NONE;
          s_d.first_fault = retry_pf_pkg::F_NONE;
          s_d.fault_reset = 1'b1;
        end
      end
      default: s_d.rt = retry_pf_pkg::RT_IDLE;
    endcase
    // wait over, clear the trip and restart from starting frequency
    // retry reset leaves thermal and brake data alone
    if (fire) begin
      s_d.rt = retry_pf_pkg::RT_RUN;
      s_d.timer = 16'h0000;
      s_d.fault_reset = 1'b1;
      s_d.shown_fault = retry_pf_pkg::F_NONE;
    end
    // restart timing follows the power-loss restart when enabled
    s_d.flying_restart = fire && (s_q.cfg.coast != retry_pf_pkg::COAST_OFF);
    // alarm shown during retry only for settings above 100
    s_d.fault_alarm = (s_d.rt == retry_pf_pkg::RT_LOCK) ||
                      ((s_d.rt == retry_pf_pkg::RT_WAIT) &&
                       (s_q.cfg.retry_cnt > retry_pf_pkg::RETRY_CNT_ALARM_BASE));

    ////////////////////////////////////////////////////////////////////////
    // Flags and terminals
    // flag covers loss decel and the stop after it
    s_d.pf_flag = (s_d.pf == retry_pf_pkg::PF_DECEL) || (s_d.pf == retry_pf_pkg::PF_STOP);
    s_d.rt_flag = (s_d.rt == retry_pf_pkg::RT_WAIT);
    for (int i = 0; i < 3; i++) begin
      s_d.term_out[i] = term_map(s_q.cfg.term[i], s_d.pf_flag, s_d.rt_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; power-on reset also clears thermal data

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q <= '0;
      s_q.cfg.stop_sel <= retry_pf_pkg::STOP_SEL_RST;
      s_q.cfg.coast <= retry_pf_pkg::COAST_OFF;
      s_q.cfg.retry_sel <= retry_pf_pkg::RETRY_SEL_RST;
      s_q.cfg.retry_cnt <= retry_pf_pkg::RETRY_CNT_RST;
      s_q.cfg.wait_t <= retry_pf_pkg::RETRY_WAIT_RST;
      s_q.pf <= retry_pf_pkg::PF_IDLE;
      s_q.rt <= retry_pf_pkg::RT_IDLE;
      s_q.first_fault <= retry_pf_pkg::F_NONE;
      s_q.shown_fault <= retry_pf_pkg::F_NONE;
      s_q.powerup <= 1'b1;
      s_q.block <= 1'b1;
      s_q.thermal_clear <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Power-up start block applies in every select, not only select 1
  // (a held start must be released once before the first run)

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign rdata_out = s_q.rdata;
  assign run_enable_out = s_q.run_en;
  assign bus_reg_decel_out = s_q.bus_decel;
  assign normal_decel_out = s_q.norm_decel;
  assign output_shutoff_out = s_q.shutoff;
  assign reaccel_out = s_q.reaccel;
  assign fault_reset_out = s_q.fault_reset;
  assign flying_restart_out = s_q.flying_restart;
  assign thermal_clear_out = s_q.thermal_clear;
  assign fault_alarm_out = s_q.fault_alarm;
  assign retry_excess_fault_out = s_q.excess;
  assign shown_fault_out = s_q.shown_fault;
  assign power_fail_decel_flag_out = s_q.pf_flag;
  assign retry_active_flag_out = s_q.rt_flag;
  assign terminal_out = s_q.term_out;

endmodule

`default_nettype wire

// ---- shared/retry_pf_pkg.sv ----
// Constants and carrier types for the power-fail and fault-retry sequencer
package retry_pf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STOP_SEL = 8'h00;
  localparam logic [7:0] OFS_COAST = 8'h04;
  localparam logic [7:0] OFS_RETRY_SEL = 8'h08;
  localparam logic [7:0] OFS_RETRY_CNT = 8'h0C;
  localparam logic [7:0] OFS_RETRY_WAIT = 8'h10;
  localparam logic [7:0] OFS_SUCCESS = 8'h14;
  localparam logic [7:0] OFS_TERM = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // Reset values and special settings
  localparam logic [1:0] STOP_SEL_RST = 2'h0;
  localparam logic [13:0] COAST_OFF = 14'h270F;
  localparam logic [2:0] RETRY_SEL_RST = 3'h0;
  localparam logic [7:0] RETRY_CNT_RST = 8'h00;
  localparam logic [7:0] RETRY_CNT_MAX_PLAIN = 8'h0A;
  localparam logic [7:0] RETRY_CNT_ALARM_BASE = 8'h64;
  localparam logic [11:0] RETRY_WAIT_RST = 12'h00A;
  localparam logic [11:0] RETRY_WAIT_MIN = 12'h001;
  localparam logic [11:0] RETRY_WAIT_MAX = 12'hE10;
  localparam logic [7:0] TERM_PF_POS = 8'h2E;
  localparam logic [7:0] TERM_PF_NEG = 8'h92;
  localparam logic [7:0] TERM_RT_POS = 8'h40;
  localparam logic [7:0] TERM_RT_NEG = 8'hA4;
  localparam logic [3:0] SUCCESS_MULT = 4'h4;
  // Time base: one tick is 0.1 s of the retry timers
  localparam longint TICK_NS = 100000000;
  localparam longint CLK_NS = 5;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_NS);
  // Fault classes reported by the drive
  typedef enum logic [4:0] {
    F_NONE = 5'h00, F_OC1 = 5'h01, F_OC2 = 5'h02, F_OC3 = 5'h03,
    F_OV1 = 5'h04, F_OV2 = 5'h05, F_OV3 = 5'h06, F_THM = 5'h07,
    F_THT = 5'h08, F_BE = 5'h09, F_GF = 5'h0A, F_USB = 5'h0B,
    F_OHT = 5'h0C, F_OLT = 5'h0D, F_OPT = 5'h0E, F_OP1 = 5'h0F,
    F_PE = 5'h10, F_MB4 = 5'h11, F_MB5 = 5'h12, F_MB6 = 5'h13,
    F_MB7 = 5'h14, F_ILF = 5'h15, F_RET = 5'h16
  } fault_t;
  // Power-fail sequence, Gray along idle-decel-stop-normal decel
  typedef enum logic [1:0] {
    PF_IDLE = 2'h0, PF_DECEL = 2'h1, PF_STOP = 2'h3, PF_NORM = 2'h2
  } pf_state_t;
  // Retry sequence, Gray along idle-wait-run-lock
  typedef enum logic [1:0] {
    RT_IDLE = 2'h0, RT_WAIT = 2'h1, RT_RUN = 2'h3, RT_LOCK = 2'h2
  } rt_state_t;
  // Software settings
  typedef struct packed {
    logic [1:0] stop_sel;
    logic [13:0] coast;
    logic [2:0] retry_sel;
    logic [7:0] retry_cnt;
    logic [11:0] wait_t;
    logic [2:0][7:0] term;
  } cfg_t;
  // Whole sequencer state
  typedef struct packed {
    cfg_t cfg;
    pf_state_t pf;
    rt_state_t rt;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] timer;
    logic [7:0] fails;
    logic [15:0] success;
    fault_t first_fault;
    fault_t shown_fault;
    logic block;
    logic powerup;
    logic run_en;
    logic bus_decel;
    logic norm_decel;
    logic shutoff;
    logic reaccel;
    logic fault_reset;
    logic flying_restart;
    logic thermal_clear;
    logic fault_alarm;
    logic excess;
    logic pf_flag;
    logic rt_flag;
    logic [2:0] term_out;
    logic [31:0] rdata;
  } state_t;
endpackage

// ---- tb/retry_pf_checker.sv ----
// Port-level assertions for the power-fail and retry sequencer
`timescale 1ns/1ps
`default_nettype none
module retry_pf_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Watched inputs
  input wire logic rd_in,
  input wire logic fault_in,
  input wire logic undervolt_in,
  input wire logic manual_reset_in,
  // Watched outputs
  input wire logic [31:0] rdata_out,
  input wire logic bus_reg_decel_out,
  input wire logic output_shutoff_out,
  input wire logic fault_reset_out,
  input wire logic flying_restart_out,
  input wire logic thermal_clear_out,
  input wire logic retry_excess_fault_out,
  input wire logic power_fail_decel_flag_out,
  input wire logic retry_active_flag_out
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Retry fire lasts exactly one cycle
  sequence s_fire;
    fault_reset_out ##1 !fault_reset_out;
  endsequence
  ////////////////////////////////////////////////////////////
  a_read_slot:
    assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside its slot");
  a_pf_flag_cause:
    assert property ($rose(power_fail_decel_flag_out) |-> bus_reg_decel_out) else $error("flag without decel");
  a_fire_pulse:
    assert property (fault_reset_out |-> s_fire) else $error("retry fire not one cycle");
  a_retry_start:
    assert property ($rose(retry_active_flag_out) |-> $past(fault_in)) else $error("retry flag without trip");
  a_excess_sticky:
    assert property (retry_excess_fault_out && !manual_reset_in |=> retry_excess_fault_out)
      else $error("excess fault dropped");
  a_shutoff_cause:
    assert property (output_shutoff_out |-> $past(undervolt_in)) else $error("shutoff without supply loss");
  a_thermal_kept:
    assert property (!$past(srst_in) |-> !thermal_clear_out) else $error("thermal data cleared outside reset");
  a_flying_fire:
    assert property (flying_restart_out |-> fault_reset_out) else $error("flying restart without fire");
endmodule
bind fault_retry_power_fail_ctrl retry_pf_checker checker_inst (.*);
`default_nettype wire

// ---- tb/ctrl_model.sv ----
// Behavioural external controller driving the start inputs
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic clk_in,
  // Commands from the bench
  input wire logic run_cmd_in,
  input wire logic dir_in,
  // Start inputs of the sequencer
  output logic fwd_out,
  output logic rev_out
);
  // start held through loss
  // Supply loss never drops the start here, so any release is a deliberate bench command
  always_ff @(posedge clk_in) begin
    fwd_out <= run_cmd_in & ~dir_in;
    rev_out <= run_cmd_in & dir_in;
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the power-fail and retry sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0, rd_in = 1'b0, undervolt_in = 1'b0, freq_zero_in = 1'b0;
  logic fault_in = 1'b0, manual_reset_in = 1'b0, run_cmd = 1'b1, dir = 1'b0, fwd, rev;
  logic [4:0] fault_code_in = 5'h00;
  logic [31:0] rdata_out;
  logic run_enable_out, bus_reg_decel_out, normal_decel_out, output_shutoff_out, reaccel_out;
  logic fault_reset_out, flying_restart_out, thermal_clear_out, fault_alarm_out, retry_excess_fault_out;
  logic power_fail_decel_flag_out, retry_active_flag_out;
  logic [4:0] shown_fault_out;
  logic [2:0] terminal_out;
  int mismatches = 0, n_tests = 0, n;
  logic [31:0] sel_tab [5] = '{32'h2, 32'h5, 32'h4, 32'h3, 32'h0};
  retry_pf_pkg::fault_t code_tab [5] = '{retry_pf_pkg::F_OC1, retry_pf_pkg::F_OC2, retry_pf_pkg::F_THM,
    retry_pf_pkg::F_THT, retry_pf_pkg::F_OC1};
  // Clock at 200 MHz
  always #2.5 clk_in = ~clk_in;
  ctrl_model ctrl_model_inst (.clk_in, .run_cmd_in(run_cmd), .dir_in(dir), .fwd_out(fwd), .rev_out(rev));
  // A tick of four clocks keeps the retry timers short
  fault_retry_power_fail_ctrl #(.TICK_CYCLES(4)) fault_retry_power_fail_ctrl_inst (.*,
    .forward_start_input_in(fwd), .reverse_start_input_in(rev));
  ////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Sample just after the edge so registered outputs have landed
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(nm, rdata_out, exp);
  endtask
  task automatic flt(input retry_pf_pkg::fault_t c);
    @(posedge clk_in);
    fault_in <= 1'b1;
    fault_code_in <= c;
    @(posedge clk_in);
    fault_in <= 1'b0;
  endtask
  task automatic mrst();
    @(posedge clk_in) manual_reset_in <= 1'b1;
    @(posedge clk_in) manual_reset_in <= 1'b0;
    step(2);
  endtask
  task automatic restart(input logic d);
    @(posedge clk_in) run_cmd <= 1'b0;
    @(posedge clk_in) dir <= d;
    step(3);
    @(posedge clk_in) run_cmd <= 1'b1;
    step(3);
  endtask
  task automatic uv(input logic v);
    @(posedge clk_in) undervolt_in <= v;
    step(3);
  endtask
  function automatic logic pick(input int k);
    return (k == 0) ? fault_reset_out : reaccel_out;
  endfunction
  // Bounded wait on a pulse; running out ends the run as a failure
  task automatic wait_on(input int k);
    n = 0;
    while (pick(k) !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 300) begin
      chk("wait", 32'h0, 32'h1);
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults();
    rd(8'h00, 32'h0, "stop_sel");
    rd(8'h04, 32'h270F, "coast");
    rd(8'h0C, 32'h0, "retry_cnt");
    rd(8'h10, 32'h00A, "wait");
    rd(8'h20, 32'h0, "unmapped");
    wr(8'h18, 32'h00A4402E);
    step(3);
    chk("terminal", terminal_out, 32'h4);
  endtask
  task automatic t_sel1();
    chk("run_blocked", run_enable_out, 32'h0);
    wr(8'h00, 32'h1);
    restart(1'b0);
    chk("run", run_enable_out, 32'h1);
    uv(1'b1);
    chk("bus_decel", bus_reg_decel_out, 32'h1);
    chk("terminal_pf", terminal_out, 32'h5);
    uv(1'b0);
    chk("keep_decel", bus_reg_decel_out, 32'h1);
    @(posedge clk_in) freq_zero_in <= 1'b1;
    step(3);
    chk("stop_flag", power_fail_decel_flag_out, 32'h1);
    chk("stay_stop", run_enable_out, 32'h0);
    @(posedge clk_in) freq_zero_in <= 1'b0;
    restart(1'b1);
    chk("rerun", run_enable_out, 32'h1);
  endtask
  task automatic t_sel2();
    wr(8'h00, 32'h2);
    uv(1'b1);
    @(posedge clk_in) undervolt_in <= 1'b0;
    wait_on(1);
    chk("reaccel", reaccel_out, 32'h1);
    uv(1'b1);
    @(posedge clk_in) run_cmd <= 1'b0;
    step(3);
    chk("norm_decel", normal_decel_out, 32'h1);
    uv(1'b0);
    @(posedge clk_in) freq_zero_in <= 1'b1;
    step(3);
    @(posedge clk_in) freq_zero_in <= 1'b0;
    restart(1'b0);
  endtask
  task automatic t_other_modes();
    wr(8'h00, 32'h0);
    uv(1'b1);
    chk("shutoff", output_shutoff_out, 32'h1);
    chk("no_flag", power_fail_decel_flag_out, 32'h0);
    uv(1'b0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h5);
    uv(1'b1);
    chk("coast_set", bus_reg_decel_out, 32'h0);
    uv(1'b0);
  endtask
  task automatic t_retry();
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h1);
    wr(8'h10, 32'h2);
    flt(retry_pf_pkg::F_OC1);
    step(2);
    chk("rt_flag", retry_active_flag_out, 32'h1);
    chk("terminal_rt", terminal_out, 32'h2);
    wait_on(0);
    chk("wait_len", 32'(n >= 3 && n <= 9), 32'h1);
    chk("flying", flying_restart_out, 32'h1);
    step(60);
    rd(8'h14, 32'h1, "success");
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h0, "success_clr");
    wr(8'h04, 32'h270F);
  endtask
  task automatic t_excess();
    wr(8'h0C, 32'h65);
    flt(retry_pf_pkg::F_OC1);
    step(2);
    chk("alarm", fault_alarm_out, 32'h1);
    wait_on(0);
    flt(retry_pf_pkg::F_OC1);
    step(2);
    chk("excess", retry_excess_fault_out, 32'h1);
    mrst();
    chk("excess_clr", retry_excess_fault_out, 32'h0);
  endtask
  task automatic t_abandon();
    wr(8'h0C, 32'h1);
    flt(retry_pf_pkg::F_OC1);
    step(2);
    flt(retry_pf_pkg::F_OV1);
    step(2);
    chk("abandon", retry_active_flag_out, 32'h0);
    chk("shown", shown_fault_out, retry_pf_pkg::F_OV1);
    rd(8'h1C, 32'h0040_4008, "status");
    mrst();
  endtask
  // Classes outside each selection, then a zero count
  task automatic t_select();
    for (int i = 0; i < 5; i++) begin
      wr(8'h0C, (i == 4) ? 32'h0 : 32'h1);
      wr(8'h08, sel_tab[i]);
      flt(code_tab[i]);
      step(2);
      chk("no_retry", retry_active_flag_out, 32'h0);
      mrst();
    end
  endtask
  initial begin
    step(16);
    @(posedge clk_in) srst_in <= 1'b0;
    step(3);
    t_defaults();
    t_sel1();
    t_sel2();
    t_other_modes();
    t_retry();
    t_excess();
    t_abandon();
    t_select();
    close_out();
  end
endmodule
`default_nettype wire
